// file: hdl/dctp_defines.svh
`ifndef DCTP_DEFINES_SVH
`define DCTP_DEFINES_SVH

// register byte offsets
`define DCTP_OFF_GEN_CTRL      12'h02C
`define DCTP_OFF_TIMER_CTRL    12'h030
`define DCTP_OFF_COUNTER       12'h034
`define DCTP_OFF_COMPARE_A     12'h038
`define DCTP_OFF_COMPARE_B     12'h03C
`define DCTP_OFF_TOP           12'h040
`define DCTP_OFF_FLAGS         12'h044
`define DCTP_OFF_MASK          12'h048
`define DCTP_OFF_PLL_CTRL      12'h04C

// timer control fields
`define DCTP_BIT_CLEAR_ON_TOP  7
`define DCTP_BIT_PWM_A         6
`define DCTP_MSB_OUT_MODE_A    5
`define DCTP_LSB_OUT_MODE_A    4
`define DCTP_MSB_CLK_SEL       3
`define DCTP_LSB_CLK_SEL       0

// general control, pll control
`define DCTP_BIT_PRESCALER_RST 1
`define DCTP_BIT_ASYNC_CLK_EN  2

// flag and mask positions
`define DCTP_BIT_COMPARE_A     6
`define DCTP_BIT_COMPARE_B     5
`define DCTP_BIT_OVERFLOW      2
`define DCTP_FLAG_MASK         8'h64

// reset values, counter limits and prescaler width
`define DCTP_RST_BYTE          8'h00
`define DCTP_COUNT_MAX         8'hFF
`define DCTP_COUNT_ZERO        8'h00
`define DCTP_PRESCALE_BITS     14

`endif

// file: hdl/dctp_pkg.sv
package dctp_pkg;

    typedef enum logic [1:0] {
        DCTP_OUT_OFF    = 2'h0,
        DCTP_OUT_TOGGLE = 2'h1,
        DCTP_OUT_CLEAR  = 2'h2,
        DCTP_OUT_SET    = 2'h3
    } dctp_out_mode_t;

    typedef enum logic [1:0] {
        DCTP_RESP_OKAY   = 2'h0,
        DCTP_RESP_SLVERR = 2'h2
    } dctp_resp_t;

endpackage

// file: hdl/dctp_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
`include "dctp_defines.svh"

module dctp_prescaler
    import dctp_pkg::*;
(
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // control
    input  wire logic       src_tick,
    input  wire logic       prescaler_reset,
    input  wire logic [3:0] clk_sel,
    // count enable out
    output logic            count_tick
);

    logic [`DCTP_PRESCALE_BITS-1:0] chain;
    logic [`DCTP_PRESCALE_BITS-1:0] tap_mask;

    // code n divides by 2^(n-1): wait until the low n-1 bits are all ones
    function automatic logic [`DCTP_PRESCALE_BITS-1:0] tap_of(input logic [3:0] sel);
        logic [`DCTP_PRESCALE_BITS+1:0] full;
        full = '0;
        full[sel] = 1'b1;
        tap_of = full[`DCTP_PRESCALE_BITS:1] - `DCTP_PRESCALE_BITS'(1);
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn || prescaler_reset) begin
            chain <= '0;
        end else if (src_tick) begin
            chain <= chain + `DCTP_PRESCALE_BITS'(1);
        end
    end

    assign tap_mask = tap_of(clk_sel);

    // code zero never ticks, so the counter holds
    assign count_tick = (clk_sel != 4'h0) && src_tick && ((chain & tap_mask) == tap_mask);

endmodule

`default_nettype wire

// file: hdl/dctp_timer.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dctp_defines.svh"

module dctp_timer
    import dctp_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // fast clock pin and port direction
    input  wire logic        fast_peripheral_clock,
    input  wire logic        port_pin_one_dir,
    // compare pins
    output logic             compare_a_pin,
    output logic             compare_a_pin_oe,
    output logic             compare_a_pin_n,
    output logic             compare_a_pin_n_oe,
    output logic             compare_b_pin_n_oe,
    // interrupt requests
    output logic             irq_compare_a,
    output logic             irq_compare_b,
    output logic             irq_overflow
);

    // software visible registers
    logic [7:0]  timer_control_reg;
    logic [7:0]  compare_a_value;
    logic [7:0]  compare_b_value;
    logic [7:0]  top_value;
    logic [7:0]  interrupt_mask_reg;
    logic        async_clock_enable;
    logic        prescaler_reset_bit;
    logic [7:0]  interrupt_flag_reg;

    // counting-side copies
    logic [7:0]  ctl_sync;
    logic [7:0]  cmp_a_sync;
    logic [7:0]  cmp_b_sync;
    logic [7:0]  top_sync;
    logic        async_sync;
    logic        psr_sync;

    // counter state
    logic [7:0]  counter_value;
    logic [7:0]  next_counter_value;
    logic [7:0]  counter_rd;
    logic [7:0]  flags_rd;
    logic [1:0]  cnt_wr_pipe;
    logic [7:0]  cnt_wr_data;
    logic [7:0]  cnt_wr_data_q;
    logic        cnt_wr_apply;
    logic        match_a;
    logic        match_b;
    logic        match_top;
    logic        ovf_evt;
    logic        set_a;
    logic        set_b;
    logic        set_ovf;
    logic        clear_now;
    logic        count_step;
    logic        pwm_a_enable;
    logic        clear_on_top;
    dctp_out_mode_t out_mode_a;

    // fast clock pin synchroniser and edge
    logic [2:0]  fast_sync;
    logic        src_tick;
    logic        count_tick;

    // bus state
    logic        aw_have;
    logic        w_have;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        wr_ok;

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `DCTP_OFF_GEN_CTRL) || (a == `DCTP_OFF_TIMER_CTRL) ||
                      (a == `DCTP_OFF_COUNTER) || (a == `DCTP_OFF_COMPARE_A) ||
                      (a == `DCTP_OFF_COMPARE_B) || (a == `DCTP_OFF_TOP) ||
                      (a == `DCTP_OFF_FLAGS) || (a == `DCTP_OFF_MASK) ||
                      (a == `DCTP_OFF_PLL_CTRL);
    endfunction

    function automatic logic wr_hit(input logic [11:0] off);
        wr_hit = do_write && wr_ok && (aw_addr == off) && w_strb[0];
    endfunction

    // write channel: address and data may come in either order
    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign do_write      = aw_have && w_have && !s_axi_bvalid;
    assign wr_ok         = addr_mapped(aw_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_have <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= DCTP_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? DCTP_RESP_OKAY : DCTP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control and compare registers read back at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control_reg  <= `DCTP_RST_BYTE;
            compare_a_value    <= `DCTP_RST_BYTE;
            compare_b_value    <= `DCTP_RST_BYTE;
            top_value          <= `DCTP_RST_BYTE;
            interrupt_mask_reg <= `DCTP_RST_BYTE;
            async_clock_enable <= 1'b0;
        end else begin
            if (wr_hit(`DCTP_OFF_TIMER_CTRL)) begin
                timer_control_reg <= w_data[7:0];
            end
            if (wr_hit(`DCTP_OFF_COMPARE_A)) begin
                compare_a_value <= w_data[7:0];
            end
            if (wr_hit(`DCTP_OFF_COMPARE_B)) begin
                compare_b_value <= w_data[7:0];
            end
            if (wr_hit(`DCTP_OFF_TOP)) begin
                top_value <= w_data[7:0];
            end
            if (wr_hit(`DCTP_OFF_MASK)) begin
                interrupt_mask_reg <= w_data[7:0] & `DCTP_FLAG_MASK;
            end
            if (wr_hit(`DCTP_OFF_PLL_CTRL)) begin
                async_clock_enable <= w_data[`DCTP_BIT_ASYNC_CLK_EN];
            end
        end
    end

    // self-clearing: zero writes have no effect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescaler_reset_bit <= 1'b0;
        end else begin
            prescaler_reset_bit <= wr_hit(`DCTP_OFF_GEN_CTRL) && w_data[`DCTP_BIT_PRESCALER_RST];
        end
    end

    // counter write goes through a staging pipe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_wr_pipe   <= 2'h0;
            cnt_wr_data   <= `DCTP_RST_BYTE;
            cnt_wr_data_q <= `DCTP_RST_BYTE;
        end else begin
            cnt_wr_pipe   <= {cnt_wr_pipe[0], wr_hit(`DCTP_OFF_COUNTER)};
            cnt_wr_data_q <= cnt_wr_data;
            if (wr_hit(`DCTP_OFF_COUNTER)) begin
                cnt_wr_data <= w_data[7:0];
            end
        end
    end

    assign cnt_wr_apply = async_sync ? cnt_wr_pipe[0] : cnt_wr_pipe[1];

    // input synchronisation stage in front of the counting logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_sync   <= `DCTP_RST_BYTE;
            cmp_a_sync <= `DCTP_RST_BYTE;
            cmp_b_sync <= `DCTP_RST_BYTE;
            top_sync   <= `DCTP_RST_BYTE;
            async_sync <= 1'b0;
            psr_sync   <= 1'b0;
        end else begin
            ctl_sync   <= timer_control_reg;
            cmp_a_sync <= compare_a_value;
            cmp_b_sync <= compare_b_value;
            top_sync   <= top_value;
            async_sync <= async_clock_enable;
            psr_sync   <= prescaler_reset_bit;
        end
    end

    assign clear_on_top = ctl_sync[`DCTP_BIT_CLEAR_ON_TOP];
    assign pwm_a_enable = ctl_sync[`DCTP_BIT_PWM_A];
    assign out_mode_a   = dctp_out_mode_t'(ctl_sync[`DCTP_MSB_OUT_MODE_A:`DCTP_LSB_OUT_MODE_A]);

    // fast clock pin: two flops, then a third for the edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_sync <= 3'h0;
        end else begin
            fast_sync <= {fast_sync[1:0], fast_peripheral_clock};
        end
    end

    // system mode steps every cycle; fast mode on each sampled rising edge
    assign src_tick = async_sync ? (fast_sync[1] && !fast_sync[2]) : 1'b1;

    dctp_prescaler u_prescaler (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .src_tick        (src_tick),
        .prescaler_reset (psr_sync),
        .clk_sel         (ctl_sync[`DCTP_MSB_CLK_SEL:`DCTP_LSB_CLK_SEL]),
        .count_tick      (count_tick)
    );

    // clear follows the top match by one cycle and wins over a tick
    assign clear_now  = (clear_on_top || pwm_a_enable) && match_top;
    assign count_step = count_tick && !cnt_wr_apply && !clear_now;

    always_comb begin
        next_counter_value = counter_value;
        if (cnt_wr_apply) begin
            // async path applies a cycle earlier, before the staged copy catches up
            next_counter_value = async_sync ? cnt_wr_data : cnt_wr_data_q;
        end else if (clear_now) begin
            next_counter_value = `DCTP_COUNT_ZERO;
        end else if (count_step) begin
            next_counter_value = counter_value + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_value <= `DCTP_COUNT_ZERO;
        end else begin
            counter_value <= next_counter_value;
        end
    end

    // matches only when counting lands on the value, never from a write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a   <= 1'b0;
            match_b   <= 1'b0;
            match_top <= 1'b0;
            ovf_evt   <= 1'b0;
        end else begin
            match_a   <= count_step && (counter_value + 8'h01 == cmp_a_sync);
            match_b   <= count_step && (counter_value + 8'h01 == cmp_b_sync);
            match_top <= count_step && (counter_value + 8'h01 == top_sync);
            ovf_evt   <= (count_step && counter_value == `DCTP_COUNT_MAX) ||
                         (clear_now && pwm_a_enable);
        end
    end

    // one more stage before the flags: the sync delay after the event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            set_a   <= 1'b0;
            set_b   <= 1'b0;
            set_ovf <= 1'b0;
        end else begin
            set_a   <= match_a;
            set_b   <= match_b;
            set_ovf <= ovf_evt;
        end
    end

    // write one clears; a set in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_flag_reg <= `DCTP_RST_BYTE;
        end else begin
            interrupt_flag_reg[`DCTP_BIT_COMPARE_A] <= set_a ||
                (interrupt_flag_reg[`DCTP_BIT_COMPARE_A] &&
                 !(wr_hit(`DCTP_OFF_FLAGS) && w_data[`DCTP_BIT_COMPARE_A]));
            interrupt_flag_reg[`DCTP_BIT_COMPARE_B] <= set_b ||
                (interrupt_flag_reg[`DCTP_BIT_COMPARE_B] &&
                 !(wr_hit(`DCTP_OFF_FLAGS) && w_data[`DCTP_BIT_COMPARE_B]));
            interrupt_flag_reg[`DCTP_BIT_OVERFLOW] <= set_ovf ||
                (interrupt_flag_reg[`DCTP_BIT_OVERFLOW] &&
                 !(wr_hit(`DCTP_OFF_FLAGS) && w_data[`DCTP_BIT_OVERFLOW]));
        end
    end

    // output sync stage for counter and flag read-back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_rd <= `DCTP_RST_BYTE;
            flags_rd   <= `DCTP_RST_BYTE;
        end else begin
            counter_rd <= counter_value;
            flags_rd   <= interrupt_flag_reg;
        end
    end

    assign irq_compare_a = interrupt_flag_reg[`DCTP_BIT_COMPARE_A] &&
                           interrupt_mask_reg[`DCTP_BIT_COMPARE_A];
    assign irq_compare_b = interrupt_flag_reg[`DCTP_BIT_COMPARE_B] &&
                           interrupt_mask_reg[`DCTP_BIT_COMPARE_B];
    assign irq_overflow  = interrupt_flag_reg[`DCTP_BIT_OVERFLOW] &&
                           interrupt_mask_reg[`DCTP_BIT_OVERFLOW];

    // channel A pin level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_a_pin <= 1'b0;
        end else if (pwm_a_enable) begin
            // high from the restart at 00 until the duty point
            if (clear_now) begin
                compare_a_pin <= 1'b1;
            end else if (match_a) begin
                compare_a_pin <= 1'b0;
            end
        end else if (match_a) begin
            unique case (out_mode_a)
                DCTP_OUT_OFF:    compare_a_pin <= compare_a_pin;
                DCTP_OUT_TOGGLE: compare_a_pin <= !compare_a_pin;
                DCTP_OUT_CLEAR:  compare_a_pin <= 1'b0;
                DCTP_OUT_SET:    compare_a_pin <= 1'b1;
            endcase
        end
    end

    // the port direction bit stays outside; pins drive only when it is set
    assign compare_a_pin_oe   = port_pin_one_dir && (pwm_a_enable || out_mode_a != DCTP_OUT_OFF);
    assign compare_a_pin_n    = !compare_a_pin;
    assign compare_a_pin_n_oe = port_pin_one_dir && pwm_a_enable;
    // channel B has no PWM control here, so its inverted output never connects
    assign compare_b_pin_n_oe = 1'b0;

    // read channel: one cycle to answer
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= DCTP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_mapped(s_axi_araddr) ? DCTP_RESP_OKAY : DCTP_RESP_SLVERR;
            unique case (s_axi_araddr)
                `DCTP_OFF_TIMER_CTRL: s_axi_rdata <= {24'h000000, timer_control_reg};
                `DCTP_OFF_COUNTER:    s_axi_rdata <= {24'h000000, counter_rd};
                `DCTP_OFF_COMPARE_A:  s_axi_rdata <= {24'h000000, compare_a_value};
                `DCTP_OFF_COMPARE_B:  s_axi_rdata <= {24'h000000, compare_b_value};
                `DCTP_OFF_TOP:        s_axi_rdata <= {24'h000000, top_value};
                `DCTP_OFF_FLAGS:      s_axi_rdata <= {24'h000000, flags_rd};
                `DCTP_OFF_MASK:       s_axi_rdata <= {24'h000000, interrupt_mask_reg};
                `DCTP_OFF_PLL_CTRL:   s_axi_rdata <= 32'(async_clock_enable) << `DCTP_BIT_ASYNC_CLK_EN;
                // general control and unmapped read zero; prescaler reset reads zero
                default:              s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// file: verification/dctp_timer_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module dctp_timer_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic port_pin_one_dir,
    input wire logic compare_a_pin,
    input wire logic compare_a_pin_oe,
    input wire logic compare_a_pin_n,
    input wire logic compare_a_pin_n_oe,
    input wire logic compare_b_pin_n_oe
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        ##[1:3] s_axi_bvalid;
    endsequence

    AST_WRITE_ANSWER: assert property (s_wr_taken |-> s_wr_answer)
        else $error("write answer late");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READ_RELEASE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    AST_RESET_IDLE: assert property ($rose(aresetn) |-> !compare_a_pin && !compare_a_pin_oe)
        else $error("pin active after reset");
    AST_B_INV_OFF: assert property (!compare_b_pin_n_oe)
        else $error("inverted b pin driven");
    AST_A_INV_PWM: assert property (compare_a_pin_n_oe |-> compare_a_pin_oe)
        else $error("inverted a pin alone");
    AST_PIN_DIR: assert property (compare_a_pin_oe |-> port_pin_one_dir)
        else $error("pin driven without direction");
    AST_INV_PAIR: assert property (compare_a_pin_n_oe |-> compare_a_pin_n != compare_a_pin)
        else $error("pin pair not complementary");
endmodule

`default_nettype wire

// file: verification/dctp_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dctp_defines.svh"

module dctp_timer_tb_top
    import dctp_pkg::*;
();
    logic        aclk = 1'b0;
    logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, p;
    logic        fast_peripheral_clock, port_pin_one_dir, fast_run, irq_compare_a, irq_compare_b;
    logic        compare_a_pin, compare_a_pin_oe, compare_a_pin_n, compare_a_pin_n_oe;
    logic        compare_b_pin_n_oe, irq_overflow;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, fdiv;
    int          failures, comparisons, m, hi;

    dctp_timer dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .fast_peripheral_clock(fast_peripheral_clock), .port_pin_one_dir(port_pin_one_dir),
        .compare_a_pin(compare_a_pin), .compare_a_pin_oe(compare_a_pin_oe), .compare_a_pin_n(compare_a_pin_n),
        .compare_a_pin_n_oe(compare_a_pin_n_oe), .compare_b_pin_n_oe(compare_b_pin_n_oe),
        .irq_compare_a(irq_compare_a), .irq_compare_b(irq_compare_b), .irq_overflow(irq_overflow)
    );

    always #10 aclk = ~aclk;

    // fast pin rises every fourth cycle, parked low when off
    always @(posedge aclk) begin
        if (!aresetn) begin
            fdiv <= 2'h0;
            fast_peripheral_clock <= 1'b0;
        end else begin
            fdiv <= fdiv + 2'h1;
            fast_peripheral_clock <= fast_run & fdiv[1];
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rdat, e);
    endtask

    // stop before clearing, else a late match sets a flag again
    task automatic halt();
        wr(`DCTP_OFF_TIMER_CTRL, 8'h00);
        wr(`DCTP_OFF_COUNTER, 8'h00);
        repeat (8) @(posedge aclk);
        wr(`DCTP_OFF_FLAGS, 8'h64);
        repeat (4) @(posedge aclk);
    endtask

    // read slack of a few cycles is absorbed by the +-16 window
    task automatic run_div(input int c, input int w, input int d);
        halt();
        wr(`DCTP_OFF_GEN_CTRL, 8'h02);
        wr(`DCTP_OFF_TIMER_CTRL, {4'h0, c[3:0]});
        repeat (w) @(posedge aclk);
        rd(`DCTP_OFF_COUNTER);
        chk(rdat >= (w - 16) / d && rdat <= (w + 16) / d, 1'b1);
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {aresetn, fast_run, port_pin_one_dir} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`DCTP_OFF_TIMER_CTRL, 32'h0);
        wr(`DCTP_OFF_TIMER_CTRL, 8'hB0);
        rc(`DCTP_OFF_TIMER_CTRL, 32'hB0);
        wr(`DCTP_OFF_GEN_CTRL, 8'h02);
        rc(`DCTP_OFF_GEN_CTRL, 32'h0);
        wr(12'h100, 8'h55);
        chk(resp, DCTP_RESP_SLVERR);
        rd(12'h100);
        chk(resp, DCTP_RESP_SLVERR);
        chk(rdat, 32'h0);
        wr(`DCTP_OFF_COMPARE_A, 8'h20);
        wr(`DCTP_OFF_COUNTER, 8'h20);
        repeat (8) @(posedge aclk);
        rc(`DCTP_OFF_COUNTER, 32'h20);
        rd(`DCTP_OFF_FLAGS);
        chk(rdat[`DCTP_BIT_COMPARE_A], 1'b0);
        $display("test registers done");
        port_pin_one_dir <= 1'b1;
        wr(`DCTP_OFF_TOP, 8'h09);
        wr(`DCTP_OFF_COMPARE_A, 8'h05);
        wr(`DCTP_OFF_COMPARE_B, 8'h07);
        wr(`DCTP_OFF_MASK, 8'h64);
        halt();
        for (m = 0; m < 4; m++) begin
            wr(`DCTP_OFF_TIMER_CTRL, {2'h2, m[1:0], 4'h1});
            repeat (30) @(posedge aclk);
            p = compare_a_pin;
            repeat (10) @(posedge aclk);
            chk(compare_a_pin_oe, m != 0);
            chk(compare_a_pin_n_oe, 1'b0);
            if (m == 1) chk(compare_a_pin, !p);
            if (m > 1) chk(compare_a_pin, m[0]);
        end
        rd(`DCTP_OFF_FLAGS);
        chk(rdat & 32'h64, 32'h60);
        chk({irq_compare_a, irq_compare_b, irq_overflow}, 3'h6);
        halt();
        chk({irq_compare_a, irq_compare_b, irq_overflow}, 3'h0);
        wr(`DCTP_OFF_COUNTER, 8'hF0);
        wr(`DCTP_OFF_TIMER_CTRL, 8'h01);
        repeat (40) @(posedge aclk);
        rd(`DCTP_OFF_FLAGS);
        chk(rdat[`DCTP_BIT_OVERFLOW], 1'b1);
        rd(`DCTP_OFF_COUNTER);
        chk(rdat > 32'h9, 1'b1);
        halt();
        $display("test compare done");
        wr(`DCTP_OFF_TIMER_CTRL, 8'h41);
        repeat (30) @(posedge aclk);
        chk(compare_a_pin_n_oe, 1'b1);
        hi = 0;
        repeat (10) begin
            @(posedge aclk);
            hi += compare_a_pin;
        end
        chk(hi >= 4 && hi <= 8, 1'b1);
        rd(`DCTP_OFF_FLAGS);
        chk(rdat[`DCTP_BIT_OVERFLOW], 1'b1);
        $display("test pwm done");
        for (m = 1; m < 16; m++)
            run_div(m, (m < 9) ? 32 << (m - 1) : 4096, 1 << (m - 1));
        wr(`DCTP_OFF_PLL_CTRL, 8'h04);
        fast_run <= 1'b1;
        wr(`DCTP_OFF_TIMER_CTRL, 8'h00);
        wr(`DCTP_OFF_COUNTER, 8'h3C);
        rc(`DCTP_OFF_COUNTER, 32'h3C);
        run_div(1, 64, 4);
        $display("test prescaler done");
        complete_run();
    end

    initial begin
        repeat (90000) @(posedge aclk);
        failures++;
        complete_run();
    end
endmodule

bind dctp_timer dctp_timer_monitor mon (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_pin_one_dir(port_pin_one_dir), .compare_a_pin(compare_a_pin),
    .compare_a_pin_oe(compare_a_pin_oe), .compare_a_pin_n(compare_a_pin_n),
    .compare_a_pin_n_oe(compare_a_pin_n_oe), .compare_b_pin_n_oe(compare_b_pin_n_oe)
);

`default_nettype wire
